// >>> src/flash_options_defs.vh
`ifndef FLASH_OPTIONS_DEFS_VH
`define FLASH_OPTIONS_DEFS_VH

// ****************************************
// Register layout
// ****************************************
`define OPT_WIDTH 16
`define OPT_BOOT_FLASH_BIT 13
`define OPT_ERASE_CRC_BIT 10
`define OPT_CHECKSUM_HI 9
`define OPT_CHECKSUM_LO 8
`define OPT_PROT_UNLOCK_BIT 5
`define OPT_WPROT_N_BIT 4
`define OPT_SEC_UNLOCK_BIT 2
`define OPT_SEC_CODE_HI 1
`define OPT_SEC_CODE_LO 0

// ****************************************
// Field encodings
// ****************************************
`define SEC_CODE_SECURE 2'h2
`define CHK_NONE_A 2'h0
`define CHK_POR_ONLY 2'h1
`define CHK_ANY_RESET 2'h2
`define CHK_NONE_B 2'h3

// ****************************************
// Reset values
// ****************************************
`define UPPER_POR_VALUE 8'h00
`define LOWER_RESET_VALUE 8'h02
`define READ_IDLE_VALUE 16'h0000

`endif

// >>> src/flash_options_access_gate.v
`timescale 1ns/1ps

// ****************************************
// Privilege check for register accesses
// ****************************************
module flash_options_access_gate (
  input wire busSel,
  input wire busWrite,
  input wire supervisorMode,
  input wire romExec,
  output reg writeTake,
  output reg readTake,
  output reg accessFault
);

  // Reads need supervisor; writes need supervisor code running from ROM
  always @* begin
    writeTake = busSel & busWrite & supervisorMode & romExec;
    readTake = busSel & ~busWrite & supervisorMode;
    accessFault = busSel & ((busWrite & ~(supervisorMode & romExec)) |
                  (~busWrite & ~supervisorMode));
  end

endmodule // flash_options_access_gate

// >>> src/flash_boot_security_options.v
`timescale 1ns/1ps
`include "flash_options_defs.vh"

// Contract
// - Low byte reloaded from option byte each reset
// - Register accessible only in supervisor mode
// - Upper byte cleared only by power-on reset
// - Bit 13 is read/write boot-from-flash flag
// - Checksum field 01 POR, 10 any reset
// - Checksum field software writable, POR-cleared
// - Protect bit writable only when unlock set
// - Protect bit low inhibits program and erase
// - Security code writable only when unlock set
// - Only code 10 means device secure
// - Secure device denies unsecure-source flash access
// - Security code reloaded each reset from flash
// - Security code forced secure during reset
// - Illegal direct access raises access error
// - Power-on reset zeroes whole upper byte
module flash_boot_security_options (
  input wire sys_clk,
  input wire rst_n,
  input wire porRst_n,
  input wire [7:0] nonvolatileOptionByte,
  input wire busSel,
  input wire busWrite,
  input wire [15:0] busWrData,
  input wire supervisorMode,
  input wire romExec,
  input wire flashReqValid,
  input wire flashReqSecureSource,
  output reg [15:0] busRdData_q,
  output reg busRdValid_q,
  output reg accessError_q,
  output reg bootFromFlashFlag_q,
  output reg eraseOnCrcFailN_q,
  output reg [1:0] bootChecksumPolicy_q,
  output reg checksumOnPor_q,
  output reg checksumOnAnyReset_q,
  output reg protectUnlock_q,
  output reg writeProtectN_q,
  output reg programEraseInhibit_q,
  output reg securityUnlock_q,
  output reg [1:0] securityCode_q,
  output reg deviceSecure_q,
  output reg flashAccessDeny_q
);

  // ****************************************
  // Loader states
  // ****************************************
  localparam [1:0] ST_LOAD = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  wire writeTake;
  wire readTake;
  wire accessFault;
  wire [15:0] regImage;
  reg [7:0] lowerNext;

  // ****************************************
  // Privilege gate
  // ****************************************
  flash_options_access_gate uGate (
    .busSel(busSel),
    .busWrite(busWrite),
    .supervisorMode(supervisorMode),
    .romExec(romExec),
    .writeTake(writeTake),
    .readTake(readTake),
    .accessFault(accessFault)
  );

  // Current register as seen by software, reserved bits zero
  assign regImage = {2'h0, bootFromFlashFlag_q, 2'h0, eraseOnCrcFailN_q,
                     bootChecksumPolicy_q, 2'h0, protectUnlock_q, writeProtectN_q,
                     1'h0, securityUnlock_q, securityCode_q};

  // ****************************************
  // Reload sequencer
  // ****************************************
  // One load cycle after every reset release, then run
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_LOAD: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_LOAD;
      end
    endcase
  end

  // State register
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Lower byte next value
  // ****************************************
  // Reload wins; writes honour unlock bits as they stood before the write
  always @* begin
    lowerNext = {2'h0, protectUnlock_q, writeProtectN_q, 1'h0, securityUnlock_q,
                 securityCode_q};
    if (state_q == ST_LOAD) begin
      lowerNext = {2'h0, nonvolatileOptionByte[5:4], 1'h0,
                   nonvolatileOptionByte[2:0]};
    end else if (writeTake) begin
      lowerNext[5] = busWrData[`OPT_PROT_UNLOCK_BIT];
      lowerNext[2] = busWrData[`OPT_SEC_UNLOCK_BIT];
      if (protectUnlock_q) begin
        lowerNext[4] = busWrData[`OPT_WPROT_N_BIT];
      end
      if (securityUnlock_q) begin
        lowerNext[1:0] = busWrData[`OPT_SEC_CODE_HI:`OPT_SEC_CODE_LO];
      end
    end
  end

  // ****************************************
  // Lower byte, every reset
  // ****************************************
  // Security code sits at secure while reset is held
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      protectUnlock_q <= 1'b0;
      writeProtectN_q <= 1'b0;
      securityUnlock_q <= 1'b0;
      securityCode_q <= `SEC_CODE_SECURE;
    end else begin
      protectUnlock_q <= lowerNext[5];
      writeProtectN_q <= lowerNext[4];
      securityUnlock_q <= lowerNext[2];
      securityCode_q <= lowerNext[1:0];
    end
  end

  // ****************************************
  // Upper byte, power-on reset only
  // ****************************************
  // Plain read/write fields, seeded later by boot code
  always @(posedge sys_clk or negedge porRst_n) begin
    if (!porRst_n) begin
      bootFromFlashFlag_q <= 1'b0;
      eraseOnCrcFailN_q <= 1'b0;
      bootChecksumPolicy_q <= 2'h0;
    end else if (writeTake && state_q == ST_RUN) begin
      bootFromFlashFlag_q <= busWrData[`OPT_BOOT_FLASH_BIT];
      eraseOnCrcFailN_q <= busWrData[`OPT_ERASE_CRC_BIT];
      bootChecksumPolicy_q <= busWrData[`OPT_CHECKSUM_HI:`OPT_CHECKSUM_LO];
    end
  end

  // ****************************************
  // Decoded status
  // ****************************************
  // Checksum policy, protection and security decodes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      checksumOnPor_q <= 1'b0;
      checksumOnAnyReset_q <= 1'b0;
      programEraseInhibit_q <= 1'b1;
      deviceSecure_q <= 1'b1;
    end else begin
      checksumOnPor_q <= (bootChecksumPolicy_q == `CHK_POR_ONLY) ||
                         (bootChecksumPolicy_q == `CHK_ANY_RESET);
      checksumOnAnyReset_q <= (bootChecksumPolicy_q == `CHK_ANY_RESET);
      programEraseInhibit_q <= ~writeProtectN_q;
      deviceSecure_q <= (securityCode_q == `SEC_CODE_SECURE);
    end
  end

  // ****************************************
  // Flash access screening
  // ****************************************
  // Deny pulse for unsecure requesters while secure
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flashAccessDeny_q <= 1'b0;
    end else begin
      flashAccessDeny_q <= flashReqValid & ~flashReqSecureSource &
                           (securityCode_q == `SEC_CODE_SECURE);
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  // Read data and access error, one cycle after the request
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busRdData_q <= `READ_IDLE_VALUE;
      busRdValid_q <= 1'b0;
      accessError_q <= 1'b0;
    end else begin
      busRdValid_q <= readTake;
      accessError_q <= accessFault;
      if (readTake) begin
        busRdData_q <= regImage;
      end else begin
        busRdData_q <= `READ_IDLE_VALUE;
      end
    end
  end

endmodule // flash_boot_security_options

// >>> dv/flash_options_assertions.sv
`timescale 1ns/1ps
module flash_options_checker (
  input logic sys_clk,
  input logic rst_n,
  input logic busSel,
  input logic busWrite,
  input logic supervisorMode,
  input logic romExec,
  input logic flashReqValid,
  input logic flashReqSecureSource,
  input logic [15:0] busRdData_q,
  input logic busRdValid_q,
  input logic accessError_q,
  input logic protectUnlock_q,
  input logic writeProtectN_q,
  input logic securityUnlock_q,
  input logic [1:0] securityCode_q,
  input logic deviceSecure_q,
  input logic flashAccessDeny_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (busSel && !busWrite && supervisorMode |=> busRdValid_q)
    else $error("read not answered");
  a_user_error: assert property (busSel && !supervisorMode |=> accessError_q && !busRdValid_q)
    else $error("user access not refused");
  a_write_error: assert property (busSel && busWrite && !romExec |=> accessError_q)
    else $error("direct write not flagged");
  a_flash_deny: assert property (
    flashReqValid && !flashReqSecureSource && securityCode_q == 2'h2 |=> flashAccessDeny_q)
    else $error("unsecure fetch not denied");
  a_secure_decode: assert property (deviceSecure_q == ($past(securityCode_q) == 2'h2))
    else $error("secure flag wrong");
  a_protect_locked: assert property (!protectUnlock_q && $past(rst_n) |=> $stable(writeProtectN_q))
    else $error("protect changed while locked");
  a_code_locked: assert property (!securityUnlock_q && $past(rst_n) |=> $stable(securityCode_q))
    else $error("code changed while locked");
  a_reset_secure: assert property (disable iff (1'b0) !rst_n |-> securityCode_q == 2'h2)
    else $error("code not secure in reset");
  a_reserved_zero: assert property (busRdValid_q |-> (busRdData_q & 16'hD8C8) == 16'h0000)
    else $error("reserved bits read set");
endmodule // flash_options_checker

// >>> dv/flash_boot_security_options_tb_top.sv
`timescale 1ns/1ps
module flash_boot_security_options_tb_top;
  reg sys_clk = 0, rst_n = 1, porRst_n = 1, busSel = 0, busWrite = 0;
  // Stand-in for the boot option flash byte that boot code copies
  reg [7:0] bootOptionByte = 8'h06;
  reg supervisorMode = 1, romExec = 1, flashReqValid = 0, flashReqSecureSource = 0;
  reg [7:0] nonvolatileOptionByte = 8'h37;
  reg [15:0] busWrData = 16'h0000;
  wire [15:0] busRdData_q;
  wire [1:0] bootChecksumPolicy_q, securityCode_q;
  wire busRdValid_q, accessError_q, bootFromFlashFlag_q, eraseOnCrcFailN_q;
  wire checksumOnPor_q, checksumOnAnyReset_q, protectUnlock_q, writeProtectN_q;
  wire programEraseInhibit_q, securityUnlock_q, deviceSecure_q, flashAccessDeny_q;
  integer n_errors = 0, checked = 0, cyc = 0, i;
  flash_boot_security_options uut (.*);
  always #5 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_errors = n_errors + 1;
      finish_test;
    end
  end
  task chk(input [15:0] s, input [15:0] e, input string n);
    begin
      checked = checked + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("BAD %s exp %h got %h", n, e, s);
      end
    end
  endtask
  // One bus access, result visible at return
  task acc(input w, input [15:0] d);
    begin
      @(negedge sys_clk);
      busSel = 1;
      busWrite = w;
      busWrData = d;
      @(negedge sys_clk);
      busSel = 0;
    end
  endtask
  task rd(input [15:0] e);
    begin
      acc(0, 16'h0000);
      chk(busRdData_q, e, "rdData");
      chk(busRdValid_q, 16'h0001, "rdValid");
    end
  endtask
  task flash_req(input s, input [15:0] e);
    begin
      @(negedge sys_clk);
      flashReqSecureSource = s;
      flashReqValid = 1;
      @(negedge sys_clk);
      flashReqValid = 0;
      chk(flashAccessDeny_q, e, "deny");
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    // Drop both resets after time zero so the async reset edge is seen
    #1;
    rst_n = 0;
    porRst_n = 0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1;
    porRst_n = 1;
    repeat (2) @(negedge sys_clk);
    rd(16'h0037);
    chk(deviceSecure_q, 16'h0000, "secure");
    acc(1, 16'hFFFF);
    rd(16'h2737);
    acc(1, 16'h0000);
    rd(16'h0000);
    chk(programEraseInhibit_q, 16'h0001, "inhibit");
    acc(1, 16'h0013);
    rd(16'h0000);
    acc(1, 16'h0024);
    acc(1, 16'h0036);
    rd(16'h0036);
    chk(deviceSecure_q, 16'h0001, "secure");
    flash_req(0, 16'h0001);
    flash_req(1, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      acc(1, 16'h2024 | (i << 8));
      @(negedge sys_clk);
      chk({checksumOnPor_q, checksumOnAnyReset_q}, {i == 1 || i == 2, i == 2}, "policy");
    end
    nonvolatileOptionByte = 8'h02;
    rst_n = 0;
    @(negedge sys_clk);
    chk(securityCode_q, 16'h0002, "rstCode");
    rst_n = 1;
    repeat (2) @(negedge sys_clk);
    rd(16'h2302);
    supervisorMode = 0;
    acc(0, 16'h0000);
    chk(accessError_q, 16'h0001, "userErr");
    supervisorMode = 1;
    romExec = 0;
    acc(1, 16'h0000);
    chk(accessError_q, 16'h0001, "wrErr");
    romExec = 1;
    rd(16'h2302);
    // Boot code seeds upper byte from the boot option byte
    acc(1, {2'b00, ~bootOptionByte[5], 2'b00, bootOptionByte[2:0], 8'h02});
    rd(16'h2602);
    chk({bootFromFlashFlag_q, eraseOnCrcFailN_q, bootChecksumPolicy_q, protectUnlock_q,
         writeProtectN_q, securityUnlock_q, securityCode_q}, 16'h01C2, "fields");
    // Power-on reset clears the seeded upper byte
    rst_n = 0;
    porRst_n = 0;
    @(negedge sys_clk);
    rst_n = 1;
    porRst_n = 1;
    repeat (2) @(negedge sys_clk);
    rd(16'h0002);
    finish_test;
  end
endmodule // flash_boot_security_options_tb_top
bind flash_boot_security_options flash_options_checker chk_i (.*);
